// ==== logic/aso_pkg.sv ====
// Purpose: Shared constants and types for the sample output port
// Assumes: One converter clock, sys_clk at 50 MHz
// Notes:   Both ends, the monitor and the testbench use these names
package aso_pkg;
  localparam int           SAMPLE_W      = 16;
  localparam int           DECIM_DEFAULT = 6;
  localparam int           SETTLE_PERIODS = 55;
  localparam int           GROUP_DELAY   = 30;
  localparam logic [15:0]  POS_FULL      = 16'h7FFF;
  localparam logic [15:0]  NEG_FULL      = 16'h8000;
  localparam logic [1:0]   MODE_DEFAULT  = 2'h0;
  localparam logic [1:0]   MODE_HALF     = 2'h1;
  localparam logic [1:0]   MODE_QUARTER  = 2'h2;
  localparam logic [1:0]   MODE_BYPASS   = 2'h3;
  localparam logic [7:0]   DECIM_HALF    = 8'h0C;
  localparam logic [7:0]   DECIM_QUARTER = 8'h18;
  localparam logic [7:0]   DECIM_BYPASS  = 8'h01;
  localparam logic [7:0]   DECIM_ZERO    = 8'h06;
  // Phase loaded at the first edge after sync, so ready falls at the second
  localparam logic [7:0]   FIRST_READY   = 8'h00;
  // Host register offsets
  localparam logic [3:0]   REG_CTRL      = 4'h0;
  localparam logic [3:0]   REG_STATUS    = 4'h1;
  localparam logic [3:0]   REG_MASK      = 4'h2;
  localparam logic [3:0]   REG_SAMPLE    = 4'h3;
  localparam logic [3:0]   REG_COUNT     = 4'h4;
  localparam int           CTRL_SYNC     = 0;
  localparam int           CTRL_ENABLE   = 1;
  localparam int           EV_SAMPLE     = 0;
  localparam int           EV_RANGE      = 1;
  localparam int           EV_SETTLED    = 2;
  localparam int           EV_W          = 3;
endpackage

// ==== logic/aso_link_if.sv ====
// Purpose: Parallel sample link between converter and host
// Assumes: Shared converter clock supplied outside
// Notes:   Bus level resolved from the device output enable
`timescale 1ns/1ps
interface aso_link_if;
  logic        syncN;
  logic        csN;
  logic        rdN;
  logic        dataReadyN;
  logic        rangeExceededFlag;
  logic [15:0] sampleOut;
  logic        sampleOeN;
  logic [15:0] sampleBus;
  assign sampleBus = sampleOeN ? 16'hFFFF : sampleOut;
  modport device (
    input  syncN, csN, rdN,
    output dataReadyN, rangeExceededFlag, sampleOut, sampleOeN
  );
  modport host (
    output syncN, csN, rdN,
    input  dataReadyN, rangeExceededFlag, sampleBus
  );
endinterface

// ==== logic/aso_device.sv ====
// Overview of operation
// - Flag high with overrange sample at ready fall
// - Flag low again with in-range sample
// - Ready falling edge marks new sample
// - Bus driven with select and read low, and driven low while sync is low
// - Sync low resets logic without clock
// - Reset clears state, bus low, ready high
// - Host releases sync on clock falling edge
// - First ready fall at second rising edge
// - Host waits 55 periods before trusting data
// - Common clock, sync pulsed together for alignment
// - Shared sync keeps converters in lockstep
// - Step settles within 55 ready periods
// - Impulse peak appears 30 periods later
// - Mode 00 decimates by six
// - Linear phase FIR, response scales with clock
// - Four modes, one raw modulator bypass
// - Two's complement, saturate 7FFF and 8000
// - Two mode inputs, MSB aligned outputs
//
// Purpose: Converter digital output side: decimation, framing, parallel port
// Assumes: modIn is the wide modulator word, sign extended, one per clock
// Notes:   Filter is a symmetric boxcar-weighted FIR of fixed length
`timescale 1ns/1ps
module aso_device #(
  parameter int IN_W  = 20,
  parameter int TAPS  = 61
) (
  input  wire logic            sys_clk,
  input  wire logic [1:0]      modeSel,
  input  wire logic [IN_W-1:0] modIn,
  aso_link_if.device           link
);
  localparam int ACC_W = IN_W + 7;

  ////////////////////////////////////////////////////////////////////////
  // Delay line and filter
  logic signed [IN_W-1:0] tapReg [TAPS];
  logic [7:0]             phaseReg;
  logic [15:0]            sampleReg;
  logic                   rangeReg;
  logic                   readyNReg;
  logic                   oeNReg;
  logic                   syncSeenReg;
  logic signed [ACC_W-1:0] accSum;
  logic [7:0]             decimLen;

  // linear phase FIR
  // Symmetric taps keep phase linear; the tap spacing is in clocks,
  // so the response tracks the clock rate. group delay 30 periods
  always_comb begin
    accSum = '0;
    for (int i = 0; i < TAPS; i++) begin
      accSum = accSum + ACC_W'(tapReg[i]);
    end
  end

  assign decimLen = (modeSel == aso_pkg::MODE_DEFAULT) ? aso_pkg::DECIM_ZERO :
                    (modeSel == aso_pkg::MODE_HALF)    ? aso_pkg::DECIM_HALF :
                    (modeSel == aso_pkg::MODE_QUARTER) ? aso_pkg::DECIM_QUARTER :
                                                         aso_pkg::DECIM_BYPASS;

  // Gain near two, so modulator overrange can reach the saturation path
  // settles within 55 periods
  logic signed [ACC_W-1:0] filtered;
  logic signed [ACC_W-1:0] chosen;
  assign filtered = accSum >>> 5;
  assign chosen   = (modeSel == aso_pkg::MODE_BYPASS) ? ACC_W'(tapReg[0]) : filtered;

  logic signed [ACC_W-1:0] shifted;
  logic                    overPos;
  logic                    overNeg;
  logic [15:0]             satCode;
  assign shifted = chosen >>> (IN_W - aso_pkg::SAMPLE_W);
  assign overPos = shifted > $signed(ACC_W'($signed(aso_pkg::POS_FULL)));
  assign overNeg = shifted < $signed({{(ACC_W-16){1'b1}}, aso_pkg::NEG_FULL});
  assign satCode = overPos ? aso_pkg::POS_FULL :
                   overNeg ? aso_pkg::NEG_FULL : shifted[15:0];

  logic phaseWrap;
  assign phaseWrap = (phaseReg >= decimLen - 8'h01);

  ////////////////////////////////////////////////////////////////////////
  // asynchronous reset on sync
  always_ff @(posedge sys_clk or negedge link.syncN) begin
    if (!link.syncN) begin
      for (int i = 0; i < TAPS; i++) begin
        tapReg[i] <= '0;
      end
    end else begin
      tapReg[0] <= modIn;
      for (int i = 1; i < TAPS; i++) begin
        tapReg[i] <= tapReg[i-1];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge link.syncN) begin
    if (!link.syncN) begin
      phaseReg    <= 8'h00;
      syncSeenReg <= 1'b0;
      sampleReg   <= 16'h0000;
      rangeReg    <= 1'b0;
      readyNReg   <= 1'b1;
    end else begin
      syncSeenReg <= 1'b1;
      if (!syncSeenReg) begin
        phaseReg <= aso_pkg::FIRST_READY;
      end else if (phaseWrap) begin
        phaseReg <= 8'h00;
      end else begin
        phaseReg <= phaseReg + 8'h01;
      end
      readyNReg <= !(syncSeenReg && (phaseReg == 8'h00 || decimLen == 8'h01));
      if (syncSeenReg && (phaseReg == 8'h00 || decimLen == 8'h01)) begin
        sampleReg <= satCode;
        rangeReg  <= overPos || overNeg;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge link.syncN) begin
    if (!link.syncN) begin
      oeNReg <= 1'b0;
    end else begin
      oeNReg <= link.csN || link.rdN;
    end
  end

  assign link.sampleOut         = sampleReg;
  assign link.sampleOeN         = oeNReg;
  assign link.dataReadyN        = readyNReg;
  assign link.rangeExceededFlag = rangeReg;
endmodule

// ==== logic/aso_host.sv ====
// Purpose: Host end: syncs the converter, fetches samples, raises events
// Assumes: Same sys_clk as the converter; strobes one cycle long
// Notes:   Sync released on the clock falling edge as recommended
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module aso_host (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic [15:0]      rdData,
  output logic             irq,
  aso_link_if.host         link
);
  typedef enum logic [1:0] {
    ASO_IDLE  = 2'b00,
    ASO_WAIT  = 2'b01,
    ASO_FETCH = 2'b11,
    ASO_LATCH = 2'b10
  } aso_state_t;

  aso_state_t  stateReg, stateNext;
  logic [1:0]  ctrlReg;
  logic [2:0]  statusReg;
  logic [2:0]  maskReg;
  logic [15:0] sampleReg;
  logic        rangeReg;
  logic [7:0]  countReg;
  logic        readyPrevReg;
  logic        syncPosReg;
  logic        syncNegReg;
  logic [15:0] rdDataReg;
  logic        irqReg;
  logic        csNReg;

  ////////////////////////////////////////////////////////////////////////
  wire wrCtrl   = wrStb && addr == aso_pkg::REG_CTRL;
  wire wrStatus = wrStb && addr == aso_pkg::REG_STATUS;
  wire wrMask   = wrStb && addr == aso_pkg::REG_MASK;
  wire readyFall = readyPrevReg && !link.dataReadyN;
  wire settled   = countReg >= 8'(aso_pkg::SETTLE_PERIODS);
  wire [2:0] events;
  assign events[aso_pkg::EV_SAMPLE]  = stateReg == ASO_LATCH && settled;
  assign events[aso_pkg::EV_RANGE]   = stateReg == ASO_LATCH && link.rangeExceededFlag;
  assign events[aso_pkg::EV_SETTLED] = readyFall && countReg == 8'(aso_pkg::SETTLE_PERIODS - 1);

  wire [15:0] rdMux =
    addr == aso_pkg::REG_CTRL   ? {14'h0000, ctrlReg} :
    addr == aso_pkg::REG_STATUS ? {13'h0000, statusReg} :
    addr == aso_pkg::REG_MASK   ? {13'h0000, maskReg} :
    addr == aso_pkg::REG_SAMPLE ? sampleReg :
    addr == aso_pkg::REG_COUNT  ? {7'h00, rangeReg, countReg} : 16'h0000;

  always_comb begin
    case (stateReg)
      ASO_IDLE:  stateNext = ctrlReg[aso_pkg::CTRL_ENABLE] ? ASO_WAIT : ASO_IDLE;
      ASO_WAIT:  stateNext = !ctrlReg[aso_pkg::CTRL_ENABLE] ? ASO_IDLE :
                             readyFall ? ASO_FETCH : ASO_WAIT;
      ASO_FETCH: stateNext = ASO_LATCH;
      ASO_LATCH: stateNext = ASO_WAIT;
      default:   stateNext = ASO_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stateReg     <= ASO_IDLE;
      ctrlReg      <= 2'h0;
      statusReg    <= 3'h0;
      maskReg      <= 3'h0;
      sampleReg    <= 16'h0000;
      rangeReg     <= 1'b0;
      countReg     <= 8'h00;
      readyPrevReg <= 1'b1;
      syncPosReg   <= 1'b1;
      rdDataReg    <= 16'h0000;
      irqReg       <= 1'b0;
      csNReg       <= 1'b1;
    end else begin
      stateReg     <= stateNext;
      readyPrevReg <= link.dataReadyN;
      if (wrCtrl) begin
        ctrlReg <= wrData[1:0];
      end else begin
        ctrlReg[aso_pkg::CTRL_SYNC] <= 1'b0;
      end
      if (wrMask) begin
        maskReg <= wrData[2:0];
      end
      // Set wins over a coincident clear
      statusReg <= (statusReg & ~(wrStatus ? wrData[2:0] : 3'h0)) | events;
      irqReg    <= |(((statusReg & ~(wrStatus ? wrData[2:0] : 3'h0)) | events) & maskReg);
      rdDataReg <= rdStb ? rdMux : 16'h0000;
      syncPosReg <= !(wrCtrl && wrData[aso_pkg::CTRL_SYNC]);
      if (!syncPosReg) begin
        countReg <= 8'h00;
      end else if (readyFall && !settled) begin
        countReg <= countReg + 8'h01;
      end
      csNReg <= !(stateNext == ASO_FETCH || stateNext == ASO_LATCH);
      if (stateReg == ASO_LATCH) begin
        sampleReg <= link.sampleBus;
        rangeReg  <= link.rangeExceededFlag;
      end
    end
  end

  always_ff @(negedge sys_clk) begin
    syncNegReg <= syncPosReg;
  end

  assign link.syncN = syncNegReg;
  assign link.csN   = csNReg;
  assign link.rdN   = csNReg;
  assign rdData     = rdDataReg;
  assign irq        = irqReg;
endmodule

// ==== tb/aso_port_monitor.sv ====
// Purpose: Concurrent checks on the converter link
// Assumes: One clock; device state defined after first sync
// Notes:   Watches link signals and modeSel only, no bind
`timescale 1ns/1ps
module aso_port_monitor (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic [1:0]  modeSel,
  input wire logic        syncN,
  input wire logic        csN,
  input wire logic        rdN,
  input wire logic        dataReadyN,
  input wire logic        rangeExceededFlag,
  input wire logic [15:0] sampleOut,
  input wire logic        sampleOeN
);
  // Device has no defined state before its first sync
  logic seenSync;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      seenSync <= 1'b0;
    end else if (!syncN) begin
      seenSync <= 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b || !seenSync);
  ////////////////////////////////////////
  bus_hiz_a: assert property (
    $past(csN || rdN) && $past(syncN) && syncN |-> sampleOeN)
    else $error("bus driven without select and read");
  sync_clear_a: assert property (
    !syncN |-> sampleOut == 16'h0000 && dataReadyN && !rangeExceededFlag)
    else $error("state not cleared during sync");
  first_ready_a: assert property (
    $rose(syncN) |-> dataReadyN ##1 dataReadyN ##1 !dataReadyN)
    else $error("first ready fall misplaced");
  decim_six_a: assert property (
    disable iff (!rst_b || !seenSync || !syncN)
    $fell(dataReadyN) && modeSel == 2'h0 && $past(modeSel, 30) == 2'h0
    |=> dataReadyN [*5] ##1 !dataReadyN)
    else $error("ready period not six");
  upd_together_a: assert property (
    syncN && $past(syncN) && (!$stable(sampleOut) || !$stable(rangeExceededFlag))
    |-> $fell(dataReadyN))
    else $error("sample or flag moved off ready fall");
  flag_code_a: assert property (
    rangeExceededFlag |-> sampleOut == aso_pkg::POS_FULL || sampleOut == aso_pkg::NEG_FULL)
    else $error("flag high on unsaturated code");
  fetch_cue_a: assert property (
    $fell(csN) |-> !$past(dataReadyN) && !rdN)
    else $error("fetch not cued by ready fall");
  fetch_len_a: assert property (
    $fell(csN) |=> !csN && !rdN ##1 csN && rdN)
    else $error("fetch strobe length wrong");
  sync_pulse_a: assert property (
    $fell(syncN) |=> syncN)
    else $error("sync pulse not one clock");
  sat_c: cover property (rangeExceededFlag && !dataReadyN);
  fetch_c: cover property ($fell(csN));
  bypass_c: cover property (modeSel == 2'h3 && !dataReadyN [*2]);
endmodule

// ==== tb/tb_adc_sample_output_port.sv ====
// Purpose: Both ends joined, host registers driven, link judged
// Assumes: Default device parameters, IN_W of 20
// Notes:   Peer device shares sync to judge lockstep
`timescale 1ns/1ps
module tb_adc_sample_output_port;
  logic        sys_clk     = 1'b0;
  logic        rst_b       = 1'b0;
  logic [3:0]  addr        = 4'h0;
  logic [15:0] wrData      = 16'h0000;
  logic        wrStb       = 1'b0;
  logic        rdStb       = 1'b0;
  logic [15:0] rdData;
  logic        irq;
  logic [1:0]  modeSel     = 2'h0;
  logic [19:0] modIn       = 20'h00000;
  int          err_total   = 0;
  int          check_count = 0;
  aso_link_if link ();
  aso_link_if peer ();
  always #10 sys_clk = ~sys_clk;
  assign peer.syncN = link.syncN;
  assign peer.csN   = 1'b1;
  assign peer.rdN   = 1'b1;
  aso_device u_aso_device (.sys_clk(sys_clk), .modeSel(modeSel), .modIn(modIn), .link(link));
  aso_device u_aso_device_b (.sys_clk(sys_clk), .modeSel(modeSel), .modIn(modIn), .link(peer));
  aso_host u_aso_host (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq), .link(link));
  aso_port_monitor u_aso_port_monitor (.sys_clk(sys_clk), .rst_b(rst_b), .modeSel(modeSel),
    .syncN(link.syncN), .csN(link.csN), .rdN(link.rdN), .dataReadyN(link.dataReadyN),
    .rangeExceededFlag(link.rangeExceededFlag), .sampleOut(link.sampleOut),
    .sampleOeN(link.sampleOeN));
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge sys_clk);
    wrStb  <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge sys_clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge sys_clk);
    rdStb <= 1'b0;
    #1 chk(rdData & m, e);
  endtask
  // Irq is a flop fed from the next status and the stored mask, so allow two edges
  task automatic wirq(input logic [3:0] a, input logic [15:0] d, input logic e);
    wr(a, d);
    repeat (2) @(posedge sys_clk);
    #1 chk({15'h0000, irq}, {15'h0000, e});
  endtask
  task automatic do_sync();
    wr(aso_pkg::REG_CTRL, 16'h0003);
    wait (link.syncN === 1'b0);
    // Judged before any rising edge, so the clear must be asynchronous
    #1 chk({15'h0000, link.dataReadyN}, 16'h0001);
    chk(link.sampleOut, 16'h0000);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    #1 chk({15'h0000, irq}, 16'h0000);
    chk({14'h0000, link.csN, link.rdN}, 16'h0003);
    rdc(4'hF, 16'hFFFF, 16'h0000);
  endtask
  task automatic t_settle();
    do_sync();
    repeat (60 * aso_pkg::DECIM_DEFAULT) @(posedge sys_clk);
    rdc(aso_pkg::REG_COUNT, 16'h00FF, 16'h0037);
    rdc(aso_pkg::REG_STATUS, 16'h0004, 16'h0004);
  endtask
  task automatic t_range();
    logic [19:0] xin [3];
    logic [15:0] code [3];
    xin  = '{20'h7FFFF, 20'h80000, 20'h00000};
    code = '{aso_pkg::POS_FULL, aso_pkg::NEG_FULL, 16'h0000};
    wirq(aso_pkg::REG_MASK, 16'h0002, 1'b0);
    wirq(aso_pkg::REG_STATUS, 16'h0002, 1'b0);
    for (int i = 0; i < 3; i++) begin
      modIn <= xin[i];
      repeat (20 * aso_pkg::DECIM_DEFAULT) @(posedge sys_clk);
      rdc(aso_pkg::REG_SAMPLE, 16'hFFFF, code[i]);
      rdc(aso_pkg::REG_COUNT, 16'h0100, (i < 2) ? 16'h0100 : 16'h0000);
    end
    // Range event stays sticky after the input returns
    wirq(aso_pkg::REG_MASK, 16'h0002, 1'b1);
    wirq(aso_pkg::REG_STATUS, 16'h0002, 1'b0);
    wirq(aso_pkg::REG_MASK, 16'h0000, 1'b0);
  endtask
  task automatic t_modes();
    int per [4];
    int n;
    per = '{aso_pkg::DECIM_DEFAULT, int'(aso_pkg::DECIM_HALF),
            int'(aso_pkg::DECIM_QUARTER), int'(aso_pkg::DECIM_BYPASS)};
    for (int m = 0; m < 4; m++) begin
      modeSel <= 2'(m);
      do_sync();
      repeat (30) @(posedge sys_clk);
      n = 0;
      // Window is a multiple of every period, so phase cannot matter
      repeat (48) begin
        @(posedge sys_clk);
        #1 n += int'(!link.dataReadyN);
        chk({15'h0000, peer.dataReadyN}, {15'h0000, link.dataReadyN});
      end
      chk(16'(n), 16'(48 / per[m]));
    end
    modeSel <= 2'h0;
    do_sync();
  endtask
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_settle();
    t_range();
    t_modes();
    wrap_up();
  end
  // Tests need about 1100 cycles; this allows several times that
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
endmodule
